// ===== tfm_sync.sv
`default_nettype none

// ----------------------------------------------------------------
// two-stage synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------
module tfm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  // asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // first stage is read only by the second stage
  always_comb begin
    next_meta = en ? d : meta;
    next_q    = en ? meta : q;
  end

  // registers only; constants under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

`default_nettype wire

// ===== tfm_traverse.sv
`default_nettype none

// Summary of operation
// - mode 0 disables traverse, 1 selects master role, 2 selects slave role
// - triangular offset added to output frequency, rates from rise and fall times
// - master ramps linearly to amplitude limit, then reverses direction
// - every reversal jumps the offset by the step size in the new direction
// - master toggles the handshake output at every direction change
// - slave ramps at a gradient from its own amplitude, rise and fall times, opposite in sign to the master
// - slave at limit before handshake switches holds offset until it switches
// - slave reverses at once when handshake switches before reaching the limit
// - offset is published as signal 14 and summed into the reference
// - master handshake is published as signal 15 for a slave drive
// - traverse starts only after reference first reached; no offset before that
// - normal ramps approach the reference; traverse times apply once active
// - resulting frequency clamped between minimum and maximum frequency while traversing
// - traverse settings are ignored while traverse operation runs
// - slave handshake input comes from a selectable source
// - base reference frequency comes from a selectable source

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
package tfm_pkg;
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_MASTER    = 2'h1;
  localparam logic [1:0]  MODE_SLAVE     = 2'h2;
  localparam int          FREQ_W         = 16;
  localparam int          TIME_W         = 15;
  localparam int          PCT_W          = 13;
  localparam int          OFS_W          = 18;
  localparam int          BUDGET_W       = 24;
  localparam int          SRC_N          = 4;
  localparam int          SEL_W          = 2;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TIME_UNIT_NS   = 10_000_000;
  localparam int          TICK_CYCLES    = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PCT_FULL_SCALE = 32'h0000_2710;
  localparam logic [15:0] TIME_MIN       = 16'h0001;
  localparam logic        DIR_RISING     = 1'h1;
  localparam logic        HS_RESET       = 1'h0;
  typedef enum logic [1:0] {TFM_IDLE, TFM_APPROACH, TFM_TRAVERSE} tfm_state_type;
endpackage

// ----------------------------------------------------------------
// traverse frequency modulator
// ----------------------------------------------------------------
module tfm_traverse #(
  parameter int TICK_CYCLES = tfm_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                                          ref_clk,
  input  wire logic                                          rst_n,
  input  wire logic                                          clk_en,
  // traverse settings (0.01 s and 0.01 % units)
  input  wire logic [1:0]                                    mode,
  input  wire logic [tfm_pkg::TIME_W-1:0]                    rise_time,
  input  wire logic [tfm_pkg::TIME_W-1:0]                    fall_time,
  input  wire logic [tfm_pkg::PCT_W-1:0]                     amplitude,
  input  wire logic [tfm_pkg::PCT_W-1:0]                     prop_step,
  // source selectors
  input  wire logic [tfm_pkg::SEL_W-1:0]                     ref_sel,
  input  wire logic [tfm_pkg::SEL_W-1:0]                     hs_sel,
  // drive limits and state
  input  wire logic [tfm_pkg::FREQ_W-1:0]                    min_freq,
  input  wire logic [tfm_pkg::FREQ_W-1:0]                    max_freq,
  input  wire logic                                          drive_run,
  input  wire logic [tfm_pkg::FREQ_W-1:0]                    actual_freq,
  input  wire logic [tfm_pkg::SRC_N-1:0][tfm_pkg::FREQ_W-1:0] ref_src,
  // handshake pins from other drives
  input  wire logic [tfm_pkg::SRC_N-1:0]                     hs_pin,
  // outputs
  output var  logic signed [tfm_pkg::OFS_W-1:0]              sweep_out,
  output var  logic                                          sweep_hs,
  output var  logic [tfm_pkg::FREQ_W-1:0]                    out_freq,
  output var  logic                                          trav_active,
  output var  logic                                          use_normal_ramps,
  output var  logic                                          cfg_locked
);

  // ----------------------------------------------------------------
  // handshake input path
  // ----------------------------------------------------------------
  logic [tfm_pkg::SRC_N-1:0] hs_sync;
  logic                      hs_now;
  logic                      hs_prev;
  logic                      hs_edge;

  tfm_sync #(.WIDTH(tfm_pkg::SRC_N)) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .en    (clk_en),
    .d     (hs_pin),
    .q     (hs_sync)
  );

  // selectable handshake source
  assign hs_now  = hs_sync[hs_sel];
  assign hs_edge = hs_now != hs_prev;

  // ----------------------------------------------------------------
  // settings shadow and derived values
  // ----------------------------------------------------------------
  logic [1:0]                   mode_l;
  logic [tfm_pkg::TIME_W-1:0]   rise_l;
  logic [tfm_pkg::TIME_W-1:0]   fall_l;
  logic [tfm_pkg::PCT_W-1:0]    amp_l;
  logic [tfm_pkg::PCT_W-1:0]    step_l;
  logic [tfm_pkg::FREQ_W-1:0]   ref_cur;
  logic [31:0]                  amp_prod;
  logic [31:0]                  step_prod;
  logic [tfm_pkg::FREQ_W-1:0]   amp_f;
  logic [tfm_pkg::FREQ_W-1:0]   step_f;
  logic signed [tfm_pkg::OFS_W-1:0] lim;
  logic signed [tfm_pkg::OFS_W-1:0] stp;

  // selectable base reference
  assign ref_cur   = ref_src[ref_sel];
  // percentages scaled onto the reference; divider is by a constant
  assign amp_prod  = 32'(ref_cur) * 32'(amp_l);
  assign step_prod = 32'(ref_cur) * 32'(step_l);
  assign amp_f     = 16'(amp_prod / tfm_pkg::PCT_FULL_SCALE);
  assign step_f    = 16'(step_prod / tfm_pkg::PCT_FULL_SCALE);
  assign lim       = $signed({2'h0, amp_f});
  assign stp       = $signed({2'h0, step_f});

  // ----------------------------------------------------------------
  // traverse engine
  // ----------------------------------------------------------------
  tfm_pkg::tfm_state_type           state;
  tfm_pkg::tfm_state_type           next_state;
  logic                             dir;
  logic                             next_dir;
  logic signed [tfm_pkg::OFS_W-1:0] next_sweep_out;
  logic [tfm_pkg::BUDGET_W-1:0]     budget;
  logic [tfm_pkg::BUDGET_W-1:0]     next_budget;
  logic [31:0]                      tick;
  logic [31:0]                      next_tick;
  logic                             next_sweep_hs;
  logic                             next_hs_prev;
  logic [tfm_pkg::FREQ_W-1:0]       next_out_freq;
  logic [1:0]                       next_mode_l;
  logic [tfm_pkg::TIME_W-1:0]       next_rise_l;
  logic [tfm_pkg::TIME_W-1:0]       next_fall_l;
  logic [tfm_pkg::PCT_W-1:0]        next_amp_l;
  logic [tfm_pkg::PCT_W-1:0]        next_step_l;
  logic                             stop;
  logic                             at_limit;
  logic                             rev;
  logic                             hold;
  logic [tfm_pkg::BUDGET_W-1:0]     time_cur;
  logic signed [tfm_pkg::OFS_W-1:0] base;
  logic signed [tfm_pkg::OFS_W-1:0] sum;

  // mode 0 or a stopped drive drops offset, direction and ramp state; the handshake output keeps its level
  assign stop     = !drive_run || (mode_l == tfm_pkg::MODE_OFF);
  assign at_limit = dir ? (sweep_out >= lim) : (sweep_out <= -lim);
  // traverse rise and fall times once active
  assign time_cur = 24'((dir ? rise_l : fall_l) == '0 ? tfm_pkg::TIME_MIN
                                                       : 16'(dir ? rise_l : fall_l));
  // master reverses at the limit; slave on handshake
  assign rev  = (state == tfm_pkg::TFM_TRAVERSE) && !stop &&
                (mode_l == tfm_pkg::MODE_MASTER ? at_limit : hs_edge);
  // slave waits at the limit for the handshake
  assign hold = (mode_l == tfm_pkg::MODE_SLAVE) && at_limit && !hs_edge;
  // master jumps from the limit itself, slave from where it stands
  assign base = (mode_l == tfm_pkg::MODE_MASTER) ? (dir ? lim : -lim) : sweep_out;

  // next-state logic of the engine
  always_comb begin
    next_state     = state;
    next_dir       = dir;
    next_sweep_out = sweep_out;
    next_budget    = budget;
    next_tick      = '0;
    next_sweep_hs  = sweep_hs;
    next_hs_prev   = hs_now;
    sum            = '0;
    case (state)
      tfm_pkg::TFM_IDLE: begin
        next_sweep_out = '0;
        next_dir       = tfm_pkg::DIR_RISING;
        next_budget    = '0;
        if (!stop) begin
          next_state = tfm_pkg::TFM_APPROACH;
        end
      end
      tfm_pkg::TFM_APPROACH: begin
        if (stop) begin
          next_state = tfm_pkg::TFM_IDLE;
        end else if (actual_freq == ref_cur) begin
          // first arrival at the reference starts traverse
          next_state = tfm_pkg::TFM_TRAVERSE;
          // slave starts against the master's direction
          next_dir   = (mode_l == tfm_pkg::MODE_MASTER);
        end
      end
      tfm_pkg::TFM_TRAVERSE: begin
        if (stop) begin
          next_state     = tfm_pkg::TFM_IDLE;
          next_sweep_out = '0;
          next_dir       = tfm_pkg::DIR_RISING;
          next_budget    = '0;
        end else if (rev) begin
          next_dir       = !dir;
          // proportional jump in the new direction
          next_sweep_out = dir ? base - stp : base + stp;
          next_budget    = '0;
          if (mode_l == tfm_pkg::MODE_MASTER) begin
            next_sweep_hs = !sweep_hs;
          end
        end else if (hold) begin
          next_budget = '0;
        end else begin
          // linear ramp: amplitude spread over the ramp time
          next_tick = (tick == 32'(TICK_CYCLES - 1)) ? '0 : tick + 32'h0000_0001;
          if (budget >= time_cur) begin
            next_sweep_out = dir ? sweep_out + 18'sd1 : sweep_out - 18'sd1;
            next_budget    = budget - time_cur;
          end
          if (tick == 32'(TICK_CYCLES - 1)) begin
            next_budget = next_budget + 24'(amp_f);
          end
        end
      end
      default: begin
        next_state = tfm_pkg::TFM_IDLE;
      end
    endcase
    if (!clk_en) begin
      next_state     = state;
      next_dir       = dir;
      next_sweep_out = sweep_out;
      next_budget    = budget;
      next_tick      = tick;
      next_sweep_hs  = sweep_hs;
      next_hs_prev   = hs_prev;
    end
    // offset summed into reference, clamped to the drive limits
    sum = $signed({2'h0, ref_cur}) + next_sweep_out;
    if (next_state != tfm_pkg::TFM_TRAVERSE) begin
      next_out_freq = ref_cur;
    end else if (sum > $signed({2'h0, max_freq})) begin
      next_out_freq = max_freq;
    end else if (sum < $signed({2'h0, min_freq})) begin
      next_out_freq = min_freq;
    end else begin
      next_out_freq = 16'(sum);
    end
    if (!clk_en) begin
      next_out_freq = out_freq;
    end
  end

  // settings pass through only while traverse is not running
  always_comb begin
    next_mode_l = mode_l;
    next_rise_l = rise_l;
    next_fall_l = fall_l;
    next_amp_l  = amp_l;
    next_step_l = step_l;
    if (clk_en && (state != tfm_pkg::TFM_TRAVERSE)) begin
      next_mode_l = mode;
      next_rise_l = rise_time;
      next_fall_l = fall_time;
      next_amp_l  = amplitude;
      next_step_l = prop_step;
    end
  end

  // registers of the engine and the settings shadow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= tfm_pkg::TFM_IDLE;
      dir              <= tfm_pkg::DIR_RISING;
      sweep_out        <= '0;
      budget           <= '0;
      tick             <= '0;
      sweep_hs         <= tfm_pkg::HS_RESET;
      hs_prev          <= tfm_pkg::HS_RESET;
      out_freq         <= '0;
      trav_active      <= 1'b0;
      use_normal_ramps <= 1'b1;
      cfg_locked       <= 1'b0;
      mode_l           <= tfm_pkg::MODE_OFF;
      rise_l           <= '0;
      fall_l           <= '0;
      amp_l            <= '0;
      step_l           <= '0;
    end else begin
      state            <= next_state;
      dir              <= next_dir;
      sweep_out        <= next_sweep_out;
      budget           <= next_budget;
      tick             <= next_tick;
      sweep_hs         <= next_sweep_hs;
      hs_prev          <= next_hs_prev;
      out_freq         <= next_out_freq;
      trav_active      <= next_state == tfm_pkg::TFM_TRAVERSE;
      use_normal_ramps <= next_state != tfm_pkg::TFM_TRAVERSE;
      cfg_locked       <= next_state == tfm_pkg::TFM_TRAVERSE;
      mode_l           <= next_mode_l;
      rise_l           <= next_rise_l;
      fall_l           <= next_fall_l;
      amp_l            <= next_amp_l;
      step_l           <= next_step_l;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_off_zero;
    clk_en && mode_l == tfm_pkg::MODE_OFF |=> sweep_out == '0 && !trav_active;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("offset not zero with mode off");

  property p_stop_zero;
    clk_en && !drive_run |=> sweep_out == '0 && dir == tfm_pkg::DIR_RISING;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("stopped drive kept offset");

  // a stop clears the offset at once, so only a running drive is held to single steps
  property p_master_limit;
    trav_active && mode_l == tfm_pkg::MODE_MASTER && clk_en && drive_run && !rev |=>
      ($past(sweep_out) - sweep_out) <= 18'sh0_0001 &&
      (sweep_out - $past(sweep_out)) <= 18'sh0_0001;
  endproperty
  a_master_limit: assert property (p_master_limit)
    else $error("master ramp not linear");

  property p_jump;
    rev && clk_en && dir |=> sweep_out == $past(base) - $past(stp) && !dir;
  endproperty
  a_jump: assert property (p_jump)
    else $error("reversal jump wrong");

  property p_hs_toggle;
    $changed(sweep_hs) |-> $past(rev) && mode_l == tfm_pkg::MODE_MASTER && dir != $past(dir);
  endproperty
  a_hs_toggle: assert property (p_hs_toggle)
    else $error("handshake toggled without reversal");

  property p_slave_hold;
    trav_active && clk_en && drive_run && hold |=> $stable(sweep_out);
  endproperty
  a_slave_hold: assert property (p_slave_hold)
    else $error("slave moved while holding");

  property p_slave_rev;
    trav_active && clk_en && drive_run && mode_l == tfm_pkg::MODE_SLAVE && hs_edge |=>
      dir != $past(dir);
  endproperty
  a_slave_rev: assert property (p_slave_rev)
    else $error("slave did not reverse");

  property p_no_early;
    !trav_active |-> sweep_out == '0 ##1 (trav_active || sweep_out == '0);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("offset before traverse start");

  property p_clamp;
    trav_active && min_freq <= max_freq && $stable(min_freq) && $stable(max_freq) &&
      $past(clk_en) |-> out_freq <= max_freq && out_freq >= min_freq;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("frequency outside limits");

  property p_lock;
    trav_active && $past(trav_active) |-> $stable(amp_l) && $stable(step_l) && $stable(mode_l);
  endproperty
  a_lock: assert property (p_lock)
    else $error("settings changed while traversing");

  c_master_rev: cover property (rev && mode_l == tfm_pkg::MODE_MASTER);
  c_slave_hold: cover property (trav_active && hold ##1 hs_edge);
  c_slave_early: cover property (trav_active && mode_l == tfm_pkg::MODE_SLAVE && rev && !at_limit);

endmodule

`default_nettype wire

// ===== tfm_peer_model.sv
`default_nettype none

// ----------------------------------------------------------------
// far drive: reversal handshake of a master traverse unit
// ----------------------------------------------------------------
module tfm_peer_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // reversal command from the bench
  input  wire logic flip,
  // handshake level towards the slave
  output var  logic hs_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // one level change per reversal, held until the next one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_out <= 1'h0;
    end else if (flip) begin
      hs_out <= !hs_out;
    end
  end
endmodule

`default_nettype wire

// ===== traverse_frequency_modulator_tb_top.sv
`default_nettype none

// ----------------------------------------------------------------
// traverse modulator bench
// ----------------------------------------------------------------
module traverse_frequency_modulator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                           ref_clk = 1'h0;
  logic                                           rst_n = 1'h0;
  logic [1:0]                                     mode = 2'h0;
  logic [tfm_pkg::TIME_W-1:0]                     rise_time = 15'h0032;
  logic [tfm_pkg::TIME_W-1:0]                     fall_time = 15'h0032;
  logic [tfm_pkg::PCT_W-1:0]                      amplitude = 13'h03E8;
  logic [tfm_pkg::PCT_W-1:0]                      prop_step = 13'h00C8;
  logic [tfm_pkg::SEL_W-1:0]                      ref_sel = 2'h0;
  logic [tfm_pkg::SEL_W-1:0]                      hs_sel = 2'h2;
  logic [tfm_pkg::FREQ_W-1:0]                     min_freq = 16'h03B6;
  logic [tfm_pkg::FREQ_W-1:0]                     max_freq = 16'h041A;
  logic                                           drive_run = 1'h0;
  logic [tfm_pkg::FREQ_W-1:0]                     actual_freq = 16'h0384;
  logic [tfm_pkg::SRC_N-1:0][tfm_pkg::FREQ_W-1:0] ref_src;
  logic [tfm_pkg::SRC_N-1:0]                      hs_pin;
  logic                                           flip = 1'h0;
  logic                                           peer_hs;
  logic signed [tfm_pkg::OFS_W-1:0]               sweep_out;
  logic                                           sweep_hs;
  logic [tfm_pkg::FREQ_W-1:0]                     out_freq;
  logic                                           trav_active;
  logic                                           use_normal_ramps;
  logic                                           cfg_locked;
  int                                             err_count = 0;
  int                                             num_checks = 0;
  int                                             cyc = 0;

  // references 1000, 1100, 1200, 1300; only pin 2 carries a handshake
  assign ref_src = {16'h0514, 16'h04B0, 16'h044C, 16'h03E8};
  assign hs_pin  = {1'h1, peer_hs, 1'h0, 1'h1};

  // short tick keeps a full sweep to a few hundred cycles
  tfm_traverse #(.TICK_CYCLES(4)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1), .mode(mode),
    .rise_time(rise_time), .fall_time(fall_time), .amplitude(amplitude),
    .prop_step(prop_step), .ref_sel(ref_sel), .hs_sel(hs_sel), .min_freq(min_freq),
    .max_freq(max_freq), .drive_run(drive_run), .actual_freq(actual_freq),
    .ref_src(ref_src), .hs_pin(hs_pin), .sweep_out(sweep_out), .sweep_hs(sweep_hs),
    .out_freq(out_freq), .trav_active(trav_active),
    .use_normal_ramps(use_normal_ramps), .cfg_locked(cfg_locked));

  tfm_peer_model peer_u (.ref_clk(ref_clk), .rst_n(rst_n), .flip(flip), .hs_out(peer_hs));

  // clock
  initial begin
    forever #5 ref_clk = !ref_clk;
  end

  // hang guard, well above the longest sequence
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic signed [31:0] exp,
                     input logic signed [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // reset levels while held
  task automatic t_reset();
    tick(19);
    chk("reset_normal_ramps", 1, use_normal_ramps);
    chk("reset_sweep", 0, sweep_out);
    chk("reset_hs", 0, sweep_hs);
    @(posedge ref_clk);
    rst_n <= 1'h1;
  endtask

  // off mode: every source mirrored, nothing superimposed
  task automatic t_off();
    @(posedge ref_clk);
    drive_run <= 1'h1;
    actual_freq <= 16'h03E8;
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      ref_sel <= 2'(s);
      tick(4);
      chk("off_freq", 32'h0000_03E8 + s * 100, out_freq);
      chk("off_active", 0, trav_active);
    end
    @(posedge ref_clk);
    ref_sel <= 2'h0;
    drive_run <= 1'h0;
    actual_freq <= 16'h0384;
  endtask

  // start in a role; no traverse until the reference is met
  task automatic t_start(input logic [1:0] m);
    @(posedge ref_clk);
    mode <= m;
    drive_run <= 1'h1;
    tick(10);
    chk("approach_active", 0, trav_active);
    chk("approach_sweep", 0, sweep_out);
    chk("approach_ramps", 1, use_normal_ramps);
    @(posedge ref_clk);
    actual_freq <= 16'h03E8;
    for (int i = 0; i < 10 && trav_active !== 1'h1; i++) tick(1);
    chk("start_active", 1, trav_active);
    chk("start_lock", 1, cfg_locked);
    chk("start_ramps", 0, use_normal_ramps);
    tick(40);
    chk("first_dir", 1, (m == tfm_pkg::MODE_MASTER) ? sweep_out > 0 : sweep_out < 0);
  endtask

  // master: amplitude 10 % of 1000, step 2 %, clamp 950..1050
  task automatic t_master();
    logic hs0;
    hs0 = sweep_hs;
    for (int i = 0; i < 3000 && sweep_hs === hs0; i++) tick(1);
    chk("m_hs_toggle", !hs0, sweep_hs);
    chk("m_top_rev", 32'sh0000_0050, sweep_out);
    chk("m_clamp_max", 32'h0000_041A, out_freq);
    @(posedge ref_clk);
    amplitude <= 13'h01F4;
    hs0 = sweep_hs;
    for (int i = 0; i < 3000 && sweep_hs === hs0; i++) tick(1);
    chk("m_hs_toggle2", !hs0, sweep_hs);
    chk("m_bot_rev", -32'sh0000_0050, sweep_out);
    chk("m_clamp_min", 32'h0000_03B6, out_freq);
  endtask

  // stop clears offset and state
  task automatic t_stop();
    @(posedge ref_clk);
    drive_run <= 1'h0;
    actual_freq <= 16'h0384;
    tick(3);
    chk("stop_sweep", 0, sweep_out);
    chk("stop_active", 0, trav_active);
    chk("stop_lock", 0, cfg_locked);
    chk("stop_freq", 32'h0000_03E8, out_freq);
  endtask

  // slave: hold at limit, then reverse on handshake before limit
  task automatic t_slave();
    // limit is 5 % of 1000 now that the shadow reloaded after the stop
    for (int i = 0; i < 3000 && sweep_out !== -18'sh0_0032; i++) tick(1);
    tick(60);
    chk("s_hold", -32'sh0000_0032, sweep_out);
    @(posedge ref_clk);
    flip <= 1'h1;
    @(posedge ref_clk);
    flip <= 1'h0;
    // jump of 20 up from the held limit; budget is empty so no ramp step yet
    tick(4);
    chk("s_rev_lim", -32'sh0000_001E, sweep_out);
    for (int i = 0; i < 3000 && sweep_out < 0; i++) tick(1);
    @(posedge ref_clk);
    flip <= 1'h1;
    @(posedge ref_clk);
    flip <= 1'h0;
    tick(8);
    // reversal near zero drops by the step of 20, then at most one ramp unit
    chk("s_rev_early", 1, sweep_out <= -18'sh0_0012 && sweep_out >= -18'sh0_0015);
    chk("s_hs_quiet", 0, sweep_hs);
  endtask

  // main sequence
  initial begin
    t_reset();
    t_off();
    t_start(tfm_pkg::MODE_MASTER);
    t_master();
    t_stop();
    t_start(tfm_pkg::MODE_SLAVE);
    t_slave();
    t_stop();
    final_report();
  end
endmodule

`default_nettype wire
